// >>> verilog/fdrc_top.sv
/*
 Flash DMA request control: sector counter, transfer request output, pause on ECC error, interrupt events.
 Assumes the ECC unit supplies the flash byte counter, a checksum-read strobe, an ECC error strobe
 and an overrun strobe, all synchronous to ref_clk.
 Assumes byte-addressed register offsets and a host that samples transfer_request_out on ref_clk.
 Assumes software clears the pause bit only after fixing the data of the failed sector.
 Unmapped reads return zero; unmapped writes are ignored.
*/
//
// Function
// - Sector field holds sectors minus one
// - Read zero still means one sector left
// - Decrement sector count after each checksum read before the last sector
// - ECC error leaves remaining count visible
// - Polarity bit selects request asserted level
// - Pulse mode asserts request for 250 ns
// - Level mode drops at counter match
// - ECC error sets pause, suspends transfer
// - Enable bit gates all requests
// - DMA completion reports source code 5
// - ECC error reports source code 3
// - Counter overrun reports source code 2
`timescale 1ns/10ps
`include "fdrc_defines.svh"
module fdrc_top
	import fdrc_pkg::*;
#(
	parameter int PULSE_CYC = `FDRC_PULSE_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [12:0] regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	input  wire logic [9:0]  flash_byte_counter,
	input  wire logic        checksumRead,
	input  wire logic        eccError,
	input  wire logic        overrun,
	output logic             transfer_request_out,
	output logic             irq
);
	// Current and next state
	fdrc_st_t q;
	fdrc_st_t d;
	// Address decode hits
	logic hitCtrl;
	logic hitDrop;
	logic hitStat;
	logic hitMask;
	logic lastSect;

	// Decode one register offset
	function automatic logic fdrcHit(input logic [12:0] a, input logic [12:0] off);
		fdrcHit = (a == off);
	endfunction

	// Next-state logic
	// Every register write, event and sequencer step is folded into one copy of the state,
	// so priorities read top to bottom: later assignments win over earlier ones.
	always_comb begin
		d        = q;
		hitCtrl  = fdrcHit(regAddr, `FDRC_OFF_CTRL);
		hitDrop  = fdrcHit(regAddr, `FDRC_OFF_DROP);
		hitStat  = fdrcHit(regAddr, `FDRC_OFF_ISTAT);
		hitMask  = fdrcHit(regAddr, `FDRC_OFF_IMASK);
		lastSect = (q.sect == `FDRC_RST_SECT);
		// Read clears status; set wins below
		if (regRd && hitStat) begin
			d.ev = `FDRC_RST_EV;
		end
		// Register writes, reserved bits dropped
		if (regWr && hitCtrl) begin
			d.sect     = regWdata[`FDRC_SECT_MSB:0];
			d.pol      = regWdata[`FDRC_POL_BIT];
			d.edgeMode = regWdata[`FDRC_EDGE_BIT];
			d.pause    = q.pause & regWdata[`FDRC_PAUSE_BIT];
			d.en       = regWdata[`FDRC_EN_BIT];
		end
		if (regWr && hitDrop) begin
			d.drop = regWdata[`FDRC_DROP_MSB:0];
		end
		if (regWr && hitMask) begin
			d.mask = regWdata[`FDRC_EV_MSB:0];
		end
		// Request sequencer
		// IDLE raises a request as soon as DMA is on and not paused, REQ holds it for the pulse
		// or until the drop point, WAIT idles until the sector's checksum read, PAUSE idles
		// until software clears the pause bit.
		unique case (q.st)
			FDRC_IDLE: begin
				d.req = 1'b0;
				if (d.en && !d.pause) begin
					d.st       = FDRC_REQ;
					d.req      = 1'b1;
					d.pulseCnt = 4'(PULSE_CYC - 1);
				end
			end
			FDRC_REQ: begin
				if (q.edgeMode) begin
					// Fixed-width pulse
					if (q.pulseCnt == 4'h0) begin
						d.req = 1'b0;
						d.st  = FDRC_WAIT;
					end else begin
						d.pulseCnt = q.pulseCnt - 4'h1;
					end
				end else if (flash_byte_counter == q.drop) begin
					d.req = 1'b0;
					d.st  = FDRC_WAIT;
				end
			end
			FDRC_WAIT: begin
				// Await end of sector
				d.req = 1'b0;
			end
			FDRC_PAUSE: begin
				// Held until software clears pause
				d.req = 1'b0;
				if (!d.pause) begin
					d.st = FDRC_IDLE;
				end
			end
		endcase
		// Sector end handling
		// The checksum read closes a sector; at a zero count it closes the whole transfer,
		// so a written zero moves exactly one sector. A checksum read while paused or idle
		// belongs to no request of ours and is ignored.
		if (checksumRead && q.en && q.st != FDRC_PAUSE && q.st != FDRC_IDLE) begin
			if (lastSect) begin
				d.en    = 1'b0;
				d.st    = FDRC_IDLE;
				d.req   = 1'b0;
				d.ev[`FDRC_SRC_DONE] = 1'b1;
			end else begin
				d.sect = q.sect - 7'h01;
				d.st   = FDRC_IDLE;
				d.req  = 1'b0;
			end
		end
		// ECC error pauses, count untouched
		// Set wins over a same-cycle write of the pause bit, so an error is never lost,
		// and the sector count keeps the number of sectors still to move minus one.
		if (eccError && q.en) begin
			d.pause = 1'b1;
			d.st    = FDRC_PAUSE;
			d.req   = 1'b0;
			d.sect  = q.sect;
			d.ev[`FDRC_SRC_ECC] = 1'b1;
		end
		if (overrun) begin
			d.ev[`FDRC_SRC_OVER] = 1'b1;
		end
		// Disabled: no request may stand, whatever the sequencer chose above.
		// A pause survives disabling, so the error stays visible to software.
		if (!d.en) begin
			d.req = 1'b0;
			if (d.st != FDRC_PAUSE) begin
				d.st = FDRC_IDLE;
			end
		end
		// Interrupt level
		d.irq = |(d.ev & d.mask);
		// Pin level registered with the state, so a polarity change cannot glitch it
		d.reqPin = d.req ^ ~d.pol;
		// Read data, one cycle later
		d.rdata = 16'h0000;
		if (regRd) begin
			if (hitCtrl) begin
				d.rdata = {q.en, q.pause, q.edgeMode, q.pol, 5'h00, q.sect};
			end else if (hitDrop) begin
				d.rdata = {6'h00, q.drop};
			end else if (hitStat) begin
				d.rdata = {10'h000, q.ev};
			end else if (hitMask) begin
				d.rdata = {10'h000, q.mask};
			end
		end
	end

	// State register
	// Synchronous reset clears every field except the request pin, which idles high
	// because the reset polarity bit selects an active-low request.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q        <= '0;
			q.reqPin <= `FDRC_RST_PIN;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flip-flops
	assign regRdata             = q.rdata;
	assign transfer_request_out = q.reqPin;
	assign irq                  = q.irq;

	// Pulse request is raised in the cycle after the sequencer leaves idle
	property p_pulse;
		@(posedge ref_clk) disable iff (rst)
		(q.st == FDRC_IDLE && d.st == FDRC_REQ && d.edgeMode && !eccError)
		|=> q.req;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse not started");

	// Pulse ends once the cycle counter runs out
	property p_pulseEnd;
		@(posedge ref_clk) disable iff (rst)
		(q.st == FDRC_REQ && q.edgeMode && q.pulseCnt == 4'h0 && !eccError && !checksumRead) |=> !q.req;
	endproperty
	a_pulseEnd: assert property (p_pulseEnd) else $error("pulse too long");

	// Level request falls after the drop point is seen
	property p_drop;
		@(posedge ref_clk) disable iff (rst)
		(q.st == FDRC_REQ && !q.edgeMode && flash_byte_counter == q.drop) |=> !q.req;
	endproperty
	a_drop: assert property (p_drop) else $error("level request not dropped");

	// Idle pin shows the inverse of the polarity bit
	property p_pol;
		@(posedge ref_clk) disable iff (rst)
		!q.req |-> (transfer_request_out == ~q.pol);
	endproperty
	a_pol: assert property (p_pol) else $error("idle level wrong");

	// No request while DMA is off
	property p_en;
		@(posedge ref_clk) disable iff (rst)
		!q.en |-> !q.req;
	endproperty
	a_en: assert property (p_en) else $error("request while disabled");

	// ECC error pauses, flags and drops the request
	property p_pause;
		@(posedge ref_clk) disable iff (rst)
		(eccError && q.en) |=> (q.pause && q.ev[`FDRC_SRC_ECC] && !q.req);
	endproperty
	a_pause: assert property (p_pause) else $error("ecc error not paused");

	// Paused count stays put for software to read
	property p_hold;
		@(posedge ref_clk) disable iff (rst)
		(q.st == FDRC_PAUSE && !(regWr && hitCtrl)) |=> ($stable(q.sect) && !q.req);
	endproperty
	a_hold: assert property (p_hold) else $error("paused count moved");

	// Checksum read of a middle sector counts down
	property p_dec;
		@(posedge ref_clk) disable iff (rst)
		(checksumRead && q.en && q.st == FDRC_WAIT && !lastSect && !eccError && !(regWr && hitCtrl))
		|=> (q.sect == $past(q.sect) - 7'h01);
	endproperty
	a_dec: assert property (p_dec) else $error("sector count not decremented");

	// Checksum read of the last sector ends the transfer
	property p_done;
		@(posedge ref_clk) disable iff (rst)
		(checksumRead && q.en && q.st == FDRC_WAIT && lastSect) |=> (q.ev[`FDRC_SRC_DONE] && !q.en);
	endproperty
	a_done: assert property (p_done) else $error("completion not flagged");

	// Overrun is always flagged
	property p_over;
		@(posedge ref_clk) disable iff (rst)
		overrun |=> q.ev[`FDRC_SRC_OVER];
	endproperty
	a_over: assert property (p_over) else $error("overrun not flagged");

	// Asserted request shows the programmed polarity
	property p_active;
		@(posedge ref_clk) disable iff (rst)
		q.req |-> (transfer_request_out == q.pol);
	endproperty
	a_active: assert property (p_active) else $error("asserted level wrong");

	// A pause holds the sequencer and forbids requests
	property p_pauseIdle;
		@(posedge ref_clk) disable iff (rst)
		q.pause |-> (q.st == FDRC_PAUSE && !q.req);
	endproperty
	a_pauseIdle: assert property (p_pauseIdle) else $error("request during pause");

	// Clearing pause with DMA on restarts from idle
	property p_resume;
		@(posedge ref_clk) disable iff (rst)
		(q.st == FDRC_PAUSE && regWr && hitCtrl && !regWdata[`FDRC_PAUSE_BIT]
			&& regWdata[`FDRC_EN_BIT] && !eccError)
		|=> (q.st == FDRC_IDLE && !q.pause);
	endproperty
	a_resume: assert property (p_resume) else $error("pause clear did not resume");

	// Read data stand only in the cycle after a read
	property p_rdIdle;
		@(posedge ref_clk) disable iff (rst)
		!regRd |=> (regRdata == 16'h0000);
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside read cycle");

	// Main scenarios
	c_pulse: cover property (@(posedge ref_clk) disable iff (rst) q.st == FDRC_REQ && q.edgeMode);
	c_level: cover property (@(posedge ref_clk) disable iff (rst) q.st == FDRC_REQ && !q.edgeMode ##1 !q.req);
	c_pause: cover property (@(posedge ref_clk) disable iff (rst) q.st == FDRC_PAUSE ##[1:50] q.st == FDRC_IDLE);
	c_done:  cover property (@(posedge ref_clk) disable iff (rst) $rose(q.ev[`FDRC_SRC_DONE]));
endmodule // fdrc_top

// >>> common/fdrc_defines.svh
/*
 Offsets, field positions, reset values and timing counts for the flash DMA request control block.
 Assumes a 40 MHz reference clock and byte-addressed register offsets.
*/
`ifndef FDRC_DEFINES_SVH
`define FDRC_DEFINES_SVH
// Register byte offsets
`define FDRC_OFF_CTRL      13'h1078
`define FDRC_OFF_DROP      13'h107A
`define FDRC_OFF_ISTAT     13'h107C
`define FDRC_OFF_IMASK     13'h107E
// Register field positions
`define FDRC_SECT_MSB      6
`define FDRC_POL_BIT       12
`define FDRC_EDGE_BIT      13
`define FDRC_PAUSE_BIT     14
`define FDRC_EN_BIT        15
`define FDRC_DROP_MSB      9
`define FDRC_EV_MSB        5
// Reset values
`define FDRC_RST_SECT      7'h00
`define FDRC_RST_DROP      10'h000
`define FDRC_RST_EV        6'h00
`define FDRC_RST_PIN       1'b1
// Interrupt source codes
`define FDRC_SRC_OVER      2
`define FDRC_SRC_ECC       3
`define FDRC_SRC_DONE      5
// Pulse timing
`define FDRC_PULSE_NS      250
`define FDRC_CLK_NS        25
`define FDRC_PULSE_CYC     ((`FDRC_PULSE_NS + `FDRC_CLK_NS - 1) / `FDRC_CLK_NS)
`endif

// >>> common/fdrc_pkg.sv
/*
 Types for the flash DMA request control block.
 Assumes the defines header is included by the design.
*/
package fdrc_pkg;
	// Request sequencer states, Gray coded in declaration order
	typedef enum logic [1:0] {
		FDRC_IDLE  = 2'b00,
		FDRC_REQ   = 2'b01,
		FDRC_WAIT  = 2'b11,
		FDRC_PAUSE = 2'b10
	} fdrc_state_t;

	// Whole block state
	typedef struct packed {
		fdrc_state_t st;
		logic [6:0]  sect;
		logic [9:0]  drop;
		logic        pol;
		logic        edgeMode;
		logic        pause;
		logic        en;
		logic [3:0]  pulseCnt;
		logic        req;
		logic        reqPin;   // Registered request pin level
		logic [5:0]  ev;
		logic [5:0]  mask;
		logic        irq;
		logic [15:0] rdata;
	} fdrc_st_t;
endpackage

// >>> dv/fdrc_host_dma.sv
/*
 Host DMA controller and byte-count model facing fdrc_top.
 Assumes ref_clk only; pol gives the asserted request level.
*/
`timescale 1ns/10ps
module fdrc_host_dma #(
	parameter int START = 40
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       reqOut,
	input  wire logic       pol,
	input  wire logic       slow,
	output logic      [9:0] cnt,
	output logic            csRead
);
	logic busy_q; // Sector in flight
	logic tick_q; // Halves the rate when slow
	// Moves one sector per request, then flags the checksum read
	always_ff @(posedge ref_clk) begin
		tick_q <= ~tick_q;
		csRead <= 1'b0;
		if (rst) begin
			busy_q <= 1'b0;
			cnt    <= 10'h000;
			tick_q <= 1'b0;
		end else if (!busy_q) begin
			if (reqOut == pol) begin
				busy_q <= 1'b1;
				cnt    <= START[9:0];
			end
		end else if (!slow || tick_q) begin
			cnt <= cnt - 10'h001;
			if (cnt == 10'h001) begin
				busy_q <= 1'b0;
				csRead <= 1'b1;
			end
		end
	end
endmodule // fdrc_host_dma

// >>> dv/tb_top.sv
/*
 Self-checking bench for fdrc_top with the host DMA model.
 Assumes the register map of the defines header and a 25 ns clock.
*/
`timescale 1ns/10ps
`include "fdrc_defines.svh"
module tb_top;
	logic        ref_clk  = 1'b0;
	logic        rst      = 1'b1;
	logic [12:0] regAddr  = 13'h0000;
	logic [15:0] regWdata = 16'h0000;
	logic        regWr    = 1'b0;
	logic        regRd    = 1'b0;
	logic        eccError = 1'b0;
	logic        overrun  = 1'b0;
	logic        pol      = 1'b0; // Asserted request level, follows the control register
	logic        slow     = 1'b0; // Model pace
	logic        rdPend   = 1'b0; // Read data due now
	logic [15:0] regRdata;
	logic [9:0]  cnt;
	logic        csRead;
	logic        reqOut;
	logic        irq;
	logic [15:0] lfsr     = 16'h6950; // Seed
	logic [15:0] expQ[$]; // Expected read data
	int          n_fail      = 0;
	int          checks_done = 0;
	int          reqCyc      = 0; // Asserted request cycles
	initial forever #12.5 ref_clk = ~ref_clk;
	fdrc_top #(.PULSE_CYC(10)) fdrc_top_i (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flash_byte_counter(cnt),
		.checksumRead(csRead), .eccError(eccError), .overrun(overrun), .transfer_request_out(reqOut), .irq(irq));
	fdrc_host_dma fdrc_host_dma_i (.ref_clk(ref_clk), .rst(rst), .reqOut(reqOut), .pol(pol), .slow(slow),
		.cnt(cnt), .csRead(csRead));
	function automatic logic [15:0] nextRand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		// Host driver learns the request level when the write lands
		if (a == `FDRC_OFF_CTRL)
			pol <= d[`FDRC_POL_BIT];
	endtask
	task automatic rd(input logic [12:0] a, input logic [15:0] exp);
		expQ.push_back(exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
	endtask
	// Bounded wait: 0 request, 1 checksum read, 2 count value, 3 irq level
	task automatic waitFor(input int sel, input logic [9:0] v);
		int i;
		for (i = 0; i < 400; i++) begin
			@(negedge ref_clk);
			if (sel == 0 ? reqOut === pol : sel == 1 ? csRead === 1'b1 : sel == 2 ? cnt === v : irq === v[0])
				break;
		end
		chk({15'h0000, i < 400}, 16'h0001);
	endtask
	task automatic strobe(input logic ecc);
		@(posedge ref_clk);
		if (ecc) eccError <= 1'b1; else overrun <= 1'b1;
		@(posedge ref_clk);
		eccError <= 1'b0;
		overrun  <= 1'b0;
	endtask
	// Read data monitor and request cycle counter
	always @(posedge ref_clk) begin
		if (rdPend)
			chk(regRdata, expQ.pop_front());
		rdPend <= regRd;
		if (reqOut === pol)
			reqCyc++;
	end
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#500000;
		n_fail++;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		rd(`FDRC_OFF_CTRL, 16'h0000);
		rd(`FDRC_OFF_DROP, 16'h0000);
		rd(13'h1000, 16'h0000);
		wr(`FDRC_OFF_CTRL, 16'h7FFF);
		rd(`FDRC_OFF_CTRL, 16'h307F);
		@(negedge ref_clk);
		chk({15'h0000, reqOut}, 16'h0000);
		repeat (4) begin
			lfsr = nextRand(lfsr);
			wr(`FDRC_OFF_DROP, lfsr);
			rd(`FDRC_OFF_DROP, lfsr & 16'h03FF);
		end
		// Pulse requests, two sectors, idle high
		wr(`FDRC_OFF_IMASK, 16'hFFFF);
		rd(`FDRC_OFF_IMASK, 16'h003F);
		wr(`FDRC_OFF_CTRL, 16'h0000);
		@(negedge ref_clk);
		chk({15'h0000, reqOut}, 16'h0001);
		reqCyc = 0;
		wr(`FDRC_OFF_CTRL, 16'hA001);
		waitFor(1, 10'h000);
		rd(`FDRC_OFF_CTRL, 16'hA000);
		waitFor(3, 10'h001);
		chk(reqCyc[15:0], 16'h0014);
		rd(`FDRC_OFF_ISTAT, 16'h0020);
		waitFor(3, 10'h000);
		// Level request, idle low, slow host
		slow <= 1'b1;
		wr(`FDRC_OFF_DROP, 16'h0014);
		wr(`FDRC_OFF_CTRL, 16'h9000);
		waitFor(2, 10'h015);
		chk({15'h0000, reqOut}, 16'h0001);
		waitFor(2, 10'h014);
		@(negedge ref_clk);
		chk({15'h0000, reqOut}, 16'h0000);
		waitFor(3, 10'h001);
		rd(`FDRC_OFF_ISTAT, 16'h0020);
		// ECC pause mid-transfer, then resume
		slow <= 1'b0;
		wr(`FDRC_OFF_CTRL, 16'hA002);
		waitFor(0, 10'h000);
		strobe(1'b1);
		rd(`FDRC_OFF_CTRL, 16'hE002);
		rd(`FDRC_OFF_ISTAT, 16'h0008);
		repeat (80) @(posedge ref_clk);
		chk({15'h0000, reqOut}, 16'h0001);
		wr(`FDRC_OFF_CTRL, 16'hA002);
		waitFor(3, 10'h001);
		rd(`FDRC_OFF_CTRL, 16'h2000);
		rd(`FDRC_OFF_ISTAT, 16'h0020);
		// Overrun with mask off, then on
		wr(`FDRC_OFF_IMASK, 16'h0000);
		strobe(1'b0);
		repeat (3) @(posedge ref_clk);
		chk({15'h0000, irq}, 16'h0000);
		wr(`FDRC_OFF_IMASK, 16'h0004);
		waitFor(3, 10'h001);
		rd(`FDRC_OFF_ISTAT, 16'h0004);
		waitFor(3, 10'h000);
		complete_run;
	end
endmodule // tb_top
